// ---- rtl/lvi_level_irq.sv ----
// level vectored interrupt controller with axi4-lite registers
`timescale 1ns/100ps

module lvi_level_irq #(
  parameter bit HAS_SLAVE_BUS = 1'b1
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // axi4-lite slave
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // peripheral events, same clock, one-cycle pulses
  input  wire logic        tm0_ovf_evt,
  input  wire logic        tm0_cap_evt,
  input  wire logic        interval_evt,
  input  wire logic        cnt_ovf_evt,
  input  wire logic        cnt_cap_evt,
  input  wire logic        mm_bus_evt,
  input  wire logic        slave_bus_evt,
  // asynchronous external pins, rising edge requests
  input  wire logic        ext_pin_irq_a,
  input  wire logic        ext_pin_irq_b,
  input  wire logic        ext_pin_irq_c,
  // cpu core side
  input  wire logic        global_irq_on_instr,
  input  wire logic        global_irq_off_instr,
  input  wire logic        cpu_irq_accept,
  input  wire logic        cpu_push_done,
  output logic             irq_req_r,
  output logic             stack_push_r,
  output logic             svc_valid_r,
  output logic [15:0]      svc_addr_r,
  output logic [2:0]       grant_level_r,
  output logic [15:0]      reset_pc_r
);
  localparam int NS = lvi_pkg::NUM_SOURCES;
  localparam int NL = lvi_pkg::NUM_LEVELS;

  logic [7:0]    level_mask_reg;
  logic [7:0]    level_priority_reg;
  logic [7:0]    system_mode_reg;
  logic [NS-1:0] pend_r;
  logic [2:0]    pin_s1_r;
  logic [2:0]    pin_s2_r;
  logic [2:0]    pin_s3_r;
  logic [NS-1:0] src_evt;
  logic [NS-1:0] hw_clr;
  logic [NS-1:0] sw_clr;
  logic [NL-1:0] lvl_pend;
  logic [NL-1:0] lvl_elig;
  logic          any_elig;
  logic [2:0]    win_lvl;
  logic [3:0]    win_src;
  logic [3:0]    win_rank;
  logic [3:0]    gnt_src_r;
  logic [7:0]    rom_rd_addr_r;
  logic [7:0]    rom_rd_data;
  logic [7:0]    vec_hi_r;
  logic          rom_wr_en;
  logic          gnt_entry;
  lvi_pkg::lvi_state_type state_r;
  // axi holding registers
  logic [11:0]   aw_addr_q;
  logic [31:0]   w_data_q;
  logic [3:0]    w_strb_q;
  logic          wr_fire;
  logic          ofs_rom_w;
  logic          ofs_rom_r;
  logic [11:0]   rom_ofs_w;
  logic [31:0]   rd_word;
  logic          rd_hit;

  // ----------------------------------------------------------------------------
  // pin synchronisers and source events
  // ----------------------------------------------------------------------------
  // pins are asynchronous; edge detect reads only the second and third stage
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_r <= 3'h0;
      pin_s2_r <= 3'h0;
      pin_s3_r <= 3'h0;
    end else begin
      pin_s1_r <= {ext_pin_irq_c, ext_pin_irq_b, ext_pin_irq_a};
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
    end
  end

  // source order equals vector order, index 0 holds the lowest vector
  assign src_evt = {slave_bus_evt & HAS_SLAVE_BUS,       // RULE14
                    pin_s2_r & ~pin_s3_r, mm_bus_evt,
                    cnt_cap_evt, cnt_ovf_evt, interval_evt,
                    tm0_cap_evt, tm0_ovf_evt};           // RULE10

  // ----------------------------------------------------------------------------
  // pending bits
  // ----------------------------------------------------------------------------
  // a new event wins over any clear arriving in the same cycle
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_r <= '0;
    end else begin
      pend_r <= (pend_r & ~hw_clr & ~sw_clr) | src_evt;
    end
  end

  // hardware clears only the first sources, the rest wait for software
  generate
    for (genvar i = 0; i < NS; i++) begin : g_clr
      if (i < lvi_pkg::NUM_HW_CLR) begin : g_hw
        assign hw_clr[i] = gnt_entry && (win_src == 4'(i)); // RULE15
      end else begin : g_sw
        assign hw_clr[i] = 1'b0; // RULE16
      end
      assign sw_clr[i] = wr_fire && (aw_addr_q == lvi_pkg::OFS_PEND)
                         && w_data_q[i];
    end
  endgenerate

  // ----------------------------------------------------------------------------
  // level requests and arbitration
  // ----------------------------------------------------------------------------
  // fold source pending bits onto their levels, then gate them
  always_comb begin
    lvl_pend = '0;
    for (int i = 0; i < NS; i++) begin
      if (pend_r[i]) begin
        lvl_pend[lvi_pkg::lvi_level_of(i)] = 1'b1; // RULE1
      end
    end
    lvl_elig = lvl_pend & level_mask_reg
               & {NL{system_mode_reg[lvi_pkg::MODE_GIE_BIT]}}; // RULE17 RULE20
  end

  // level order from the priority setting only, numbers are just names
  always_comb begin
    any_elig = 1'b0;
    win_lvl  = 3'h0;
    win_rank = 4'hF;
    for (int l = 0; l < NL; l++) begin
      if (lvl_elig[l] &&
          lvi_pkg::lvi_rank(3'(l), level_priority_reg) < win_rank) begin
        win_rank = lvi_pkg::lvi_rank(3'(l), level_priority_reg); // RULE3 RULE5
        win_lvl  = 3'(l);
        any_elig = 1'b1;
      end
    end
  end

  // inside a level the lowest vector wins: scan down so index 0 lands last
  always_comb begin
    win_src = 4'h0;
    for (int i = NS - 1; i >= 0; i--) begin
      if (pend_r[i] && lvi_pkg::lvi_level_of(i) == win_lvl) begin
        win_src = 4'(i); // RULE2 RULE4
      end
    end
  end

  // ----------------------------------------------------------------------------
  // grant sequence
  // ----------------------------------------------------------------------------
  assign gnt_entry = (state_r == lvi_pkg::ST_IDLE) && any_elig
                     && cpu_irq_accept;

  // push, then two vector bytes: high byte first, next byte low
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r       <= lvi_pkg::ST_IDLE;
      gnt_src_r     <= 4'h0;
      grant_level_r <= 3'h0;
      stack_push_r  <= 1'b0;
      svc_valid_r   <= 1'b0;
      svc_addr_r    <= lvi_pkg::RESET_PC;
      rom_rd_addr_r <= 8'h00;
      vec_hi_r      <= 8'h00;
    end else begin
      svc_valid_r <= 1'b0;
      case (state_r)
        lvi_pkg::ST_IDLE: begin
          if (gnt_entry) begin
            gnt_src_r     <= win_src;
            grant_level_r <= win_lvl;
            stack_push_r  <= 1'b1; // RULE6
            state_r       <= lvi_pkg::ST_PUSH;
          end
        end
        lvi_pkg::ST_PUSH: begin
          if (cpu_push_done) begin
            stack_push_r  <= 1'b0;
            rom_rd_addr_r <= lvi_pkg::lvi_vec_of(int'(gnt_src_r)); // RULE7
            state_r       <= lvi_pkg::ST_FETCH_A;
          end
        end
        lvi_pkg::ST_FETCH_A: begin
          rom_rd_addr_r <= rom_rd_addr_r + 8'h01;
          state_r       <= lvi_pkg::ST_FETCH_B;
        end
        lvi_pkg::ST_FETCH_B: begin
          vec_hi_r <= rom_rd_data;
          state_r  <= lvi_pkg::ST_FETCH_C;
        end
        lvi_pkg::ST_FETCH_C: begin
          svc_addr_r  <= {vec_hi_r, rom_rd_data}; // RULE7
          svc_valid_r <= 1'b1;
          state_r     <= lvi_pkg::ST_IDLE;
        end
        default: state_r <= lvi_pkg::ST_IDLE;
      endcase
    end
  end

  // request line and reset entry point for the core
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_req_r  <= 1'b0;
      reset_pc_r <= lvi_pkg::RESET_PC; // RULE9
    end else begin
      irq_req_r  <= any_elig && (state_r == lvi_pkg::ST_IDLE) && !gnt_entry;
      reset_pc_r <= lvi_pkg::RESET_PC;
    end
  end

  // ----------------------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------------------
  // enable instruction wins over grant clear; grant clear over software write
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      system_mode_reg <= lvi_pkg::MODE_RST; // RULE18
    end else begin
      if (wr_fire && aw_addr_q == lvi_pkg::OFS_MODE && w_strb_q[0]) begin
        system_mode_reg <= w_data_q[7:0];
      end
      if (gnt_entry || global_irq_off_instr) begin
        system_mode_reg[lvi_pkg::MODE_GIE_BIT] <= 1'b0; // RULE6 RULE18
      end
      if (global_irq_on_instr) begin
        system_mode_reg[lvi_pkg::MODE_GIE_BIT] <= 1'b1; // RULE18
      end
    end
  end

  // mask and priority only change under software control
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      level_mask_reg     <= lvi_pkg::MASK_RST;
      level_priority_reg <= lvi_pkg::PRIO_RST;
    end else if (wr_fire && w_strb_q[0]) begin
      if (aw_addr_q == lvi_pkg::OFS_MASK) begin
        level_mask_reg <= w_data_q[7:0]; // RULE17
      end
      if (aw_addr_q == lvi_pkg::OFS_PRIO) begin
        level_priority_reg <= w_data_q[7:0]; // RULE19
      end
    end
  end

  // ----------------------------------------------------------------------------
  // axi4-lite write channel
  // ----------------------------------------------------------------------------
  assign wr_fire   = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign rom_ofs_w = aw_addr_q - lvi_pkg::OFS_ROM_BASE;
  assign ofs_rom_w = aw_addr_q >= lvi_pkg::OFS_ROM_BASE;
  assign rom_wr_en = wr_fire && ofs_rom_w && w_strb_q[0];

  // address and data are held apart until both have arrived
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= lvi_pkg::RESP_OKAY;
      aw_addr_q     <= 12'h000;
      w_data_q      <= 32'h0000_0000;
      w_strb_q      <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_q     <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_q     <= s_axi_wdata;
        w_strb_q     <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (ofs_rom_w || aw_addr_q == lvi_pkg::OFS_MASK ||
                         aw_addr_q == lvi_pkg::OFS_PRIO ||
                         aw_addr_q == lvi_pkg::OFS_MODE ||
                         aw_addr_q == lvi_pkg::OFS_PEND) ?
                        lvi_pkg::RESP_OKAY : lvi_pkg::RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // axi4-lite read channel
  // ----------------------------------------------------------------------------
  // vector bytes are write only: the single read port belongs to the grant
  assign ofs_rom_r = s_axi_araddr >= lvi_pkg::OFS_ROM_BASE;
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit  = 1'b1;
    case (s_axi_araddr)
      lvi_pkg::OFS_MASK:   rd_word[7:0]    = level_mask_reg;
      lvi_pkg::OFS_PRIO:   rd_word[7:0]    = level_priority_reg;
      lvi_pkg::OFS_MODE:   rd_word[7:0]    = system_mode_reg;
      lvi_pkg::OFS_PEND:   rd_word[NS-1:0] = pend_r;
      lvi_pkg::OFS_LVLREQ: rd_word[NL-1:0] = lvl_pend;
      lvi_pkg::OFS_STATUS: rd_word[7:0]    = {state_r != lvi_pkg::ST_IDLE,
                                              grant_level_r, gnt_src_r};
      default:             rd_hit          = ofs_rom_r;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= lvi_pkg::RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_word;
        s_axi_rresp   <= rd_hit ? lvi_pkg::RESP_OKAY : lvi_pkg::RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // vector memory
  // ----------------------------------------------------------------------------
  lvi_vector_rom #(
    .DEPTH (lvi_pkg::ROM_DEPTH),
    .AW    (8)
  ) u_rom (
    .sys_clk   (sys_clk),
    .wr_en     (rom_wr_en),
    .wr_addr   (rom_ofs_w[9:2]),
    .wr_data   (w_data_q[7:0]),
    .rd_addr   (rom_rd_addr_r),
    .rd_data_r (rom_rd_data)
  );
endmodule // lvi_level_irq

// ---- inc/lvi_pkg.sv ----
// package: constants, source map and priority decode for the level interrupt
// ----------------------------------------------------------------------------
// How it works
// RULE1: eight request levels, every source on one
// RULE2: several vectors per level, fixed hardware order
// RULE3: level order comes only from priority register
// RULE4: same level contention grants lowest vector address
// RULE5: smaller priority value means higher priority
// RULE6: grant disables interrupts, pushes pc and flags
// RULE7: target is vector byte then next byte
// RULE8: vectors live in rom bytes 00 to FF
// RULE9: execution starts at 0100 after reset
// RULE10: ten sources, each with its own vector
// RULE11: level 0 timer overflow E0 above capture E2
// RULE12: level 1 interval E4, level 2 E6 E8
// RULE13: level 3 serial EA, levels 4-6 pins
// RULE14: level 7 slave serial F2, optional variant
// RULE15: hardware clears first four sources at entry
// RULE16: software clears the remaining pending bits itself
// RULE17: mask bit set enables level, clear masks
// RULE18: mode bit 0 global enable, reset clears
// RULE19: three groups ordered by priority bits 7,4,1
// RULE20: eligible needs pending, mask set, global enable
// ----------------------------------------------------------------------------
package lvi_pkg;

  // ----------------------------------------------------------------------------
  // sizes and fixed addresses
  // ----------------------------------------------------------------------------
  localparam int          NUM_LEVELS   = 8;  // RULE1
  localparam int          NUM_SOURCES  = 10; // RULE10
  localparam int          NUM_HW_CLR   = 4;  // sources 0..3 cleared by hardware
  localparam logic [7:0]  VEC_BASE     = 8'hE0;
  localparam logic [7:0]  VEC_STEP     = 8'h02;
  localparam logic [15:0] RESET_PC     = 16'h0100; // RULE9
  localparam int          ROM_DEPTH    = 256;      // RULE8
  localparam int          AXI_AW       = 12;

  // ----------------------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------------------
  localparam logic [11:0] OFS_MASK     = 12'h000;
  localparam logic [11:0] OFS_PRIO     = 12'h004;
  localparam logic [11:0] OFS_MODE     = 12'h008;
  localparam logic [11:0] OFS_PEND     = 12'h00C;
  localparam logic [11:0] OFS_LVLREQ   = 12'h010;
  localparam logic [11:0] OFS_STATUS   = 12'h014;
  localparam logic [11:0] OFS_ROM_BASE = 12'h400; // byte n at base + 4*n
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  localparam logic [7:0]  MODE_RST     = 8'h00;  // RULE18
  localparam logic [7:0]  MASK_RST     = 8'h00;
  localparam logic [7:0]  PRIO_RST     = 8'h00;
  localparam int          MODE_GIE_BIT = 0;

  // ----------------------------------------------------------------------------
  // source to level map: 0 tm0 ovf, 1 tm0 cap, 2 interval, 3 cnt ovf,
  // 4 cnt cap, 5 multi-master bus, 6..8 pins a..c, 9 slave bus
  // ----------------------------------------------------------------------------
  localparam logic [29:0] SRC_LEVEL = {3'h7, 3'h6, 3'h5, 3'h4, 3'h3,
                                       3'h2, 3'h2, 3'h1, 3'h0, 3'h0};
  // RULE11 RULE12 RULE13 RULE14

  typedef enum {ST_IDLE, ST_PUSH, ST_FETCH_A, ST_FETCH_B, ST_FETCH_C}
    lvi_state_type;

  // vector address of a source, lowest index has the lowest address
  function automatic logic [7:0] lvi_vec_of(input int src);
    lvi_vec_of = VEC_BASE + VEC_STEP * src[7:0]; // RULE10
  endfunction

  // level of a source
  function automatic logic [2:0] lvi_level_of(input int src);
    lvi_level_of = SRC_LEVEL[src*3 +: 3];
  endfunction

  // rank of a level under a priority setting, 0 is served first
  function automatic logic [3:0] lvi_rank(input logic [2:0] lvl,
                                          input logic [7:0] prio);
    logic [1:0] ga;
    logic [1:0] gb;
    logic [1:0] gc;
    logic [1:0] sub;
    logic [1:0] grp;
    ga  = 2'h0;
    gb  = 2'h1;
    gc  = 2'h2;
    sub = 2'h0;
    grp = 2'h0;
    case ({prio[7], prio[4], prio[1]}) // RULE19
      3'h1:    begin gb = 2'h0; gc = 2'h1; ga = 2'h2; end
      3'h3:    begin gb = 2'h0; ga = 2'h1; gc = 2'h2; end
      3'h4:    begin gc = 2'h0; ga = 2'h1; gb = 2'h2; end
      3'h5:    begin gc = 2'h0; gb = 2'h1; ga = 2'h2; end
      3'h6:    begin ga = 2'h0; gc = 2'h1; gb = 2'h2; end
      default: begin ga = 2'h0; gb = 2'h1; gc = 2'h2; end
    endcase
    case (lvl) // RULE3
      3'h0: begin grp = ga; sub = {1'b0, prio[0]}; end
      3'h1: begin grp = ga; sub = {1'b0, ~prio[0]}; end
      3'h2: begin grp = gb; sub = prio[2] ? 2'h2 : 2'h0; end
      3'h3: begin grp = gb; sub = {1'b0, prio[3]} + {1'b0, ~prio[2]}; end
      3'h4: begin grp = gb; sub = {1'b0, ~prio[3]} + {1'b0, ~prio[2]}; end
      3'h5: begin grp = gc; sub = prio[5] ? 2'h2 : 2'h0; end
      3'h6: begin grp = gc; sub = {1'b0, prio[6]} + {1'b0, ~prio[5]}; end
      default: begin grp = gc; sub = {1'b0, ~prio[6]} + {1'b0, ~prio[5]}; end
    endcase
    lvi_rank = {grp, 2'h0} - {2'h0, grp} + {2'h0, sub}; // RULE5
  endfunction

endpackage

// ---- rtl/lvi_vector_rom.sv ----
// vector area byte store with a registered read port
`timescale 1ns/100ps

// ----------------------------------------------------------------------------
// vector byte memory
// ----------------------------------------------------------------------------
module lvi_vector_rom #(
  parameter int DEPTH = 256,
  parameter int AW    = 8
) (
  input  wire logic          sys_clk,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [7:0]    wr_data,
  input  wire logic [AW-1:0] rd_addr,
  output logic      [7:0]    rd_data_r
);
  logic [7:0] mem [DEPTH];

  // contents are loaded by software, so no reset: rom-like storage
  always_ff @(posedge sys_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data; // RULE8
    end
    rd_data_r <= mem[rd_addr];
  end
endmodule // lvi_vector_rom

// ---- bench/lvi_level_irq_chk.sv ----
// checker: grant, push and service timing of the level interrupt block
`timescale 1ns/100ps

// ----------------------------------------------------------------------------
// grant sequencing checker
// ----------------------------------------------------------------------------
module lvi_level_irq_chk (
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic        global_irq_off_instr,
  input wire logic        cpu_irq_accept,
  input wire logic        cpu_push_done,
  input wire logic        irq_req_r,
  input wire logic        stack_push_r,
  input wire logic        svc_valid_r,
  input wire logic [15:0] svc_addr_r,
  input wire logic [15:0] reset_pc_r
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  // grant moment and end of the stack push phase
  sequence s_grant;
    $rose(stack_push_r);
  endsequence
  sequence s_push_end;
    $fell(stack_push_r);
  endsequence

  a_reset_pc_fixed: assert property (reset_pc_r == 16'h0100)
    else $error("reset pc moved");
  a_grant_quiets_req: assert property (s_grant |-> !irq_req_r &&
    $past(cpu_irq_accept)) else $error("grant without accept");
  a_busy_no_req: assert property (stack_push_r |-> !irq_req_r)
    else $error("request while pushing");
  a_accept_grants: assert property (irq_req_r && cpu_irq_accept &&
    !global_irq_off_instr |=> stack_push_r) else $error("accept ignored");
  a_push_waits: assert property (stack_push_r && !cpu_push_done
    |=> stack_push_r) else $error("push dropped early");
  a_fetch_time: assert property (s_push_end |-> $past(cpu_push_done)
    ##3 svc_valid_r) else $error("service address late");
  a_svc_one_cycle: assert property (svc_valid_r |=> !svc_valid_r)
    else $error("service strobe too long");
  a_addr_moves: assert property ($changed(svc_addr_r) |-> svc_valid_r)
    else $error("service address moved alone");
endmodule // lvi_level_irq_chk

bind lvi_level_irq lvi_level_irq_chk u_chk (.sys_clk, .rst_n,
  .global_irq_off_instr, .cpu_irq_accept, .cpu_push_done, .irq_req_r,
  .stack_push_r, .svc_valid_r, .svc_addr_r, .reset_pc_r);

// ---- bench/lvi_core_model.sv ----
// partner: cpu core that accepts grants and finishes the stack push
`timescale 1ns/100ps

// ----------------------------------------------------------------------------
// core model
// ----------------------------------------------------------------------------
module lvi_core_model (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       accept_en,
  input  wire logic [3:0] push_wait,
  input  wire logic       stack_push_r,
  output logic            cpu_irq_accept,
  output logic            cpu_push_done
);
  logic [3:0] cnt_r;

  // push of pc and flags takes push_wait + 2 cycles, so slow cores are tried
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r          <= 4'h0;
      cpu_push_done  <= 1'b0;
      cpu_irq_accept <= 1'b0;
    end else begin
      cpu_irq_accept <= accept_en;
      cnt_r          <= stack_push_r ? cnt_r + 4'h1 : 4'h0;
      cpu_push_done  <= stack_push_r && cnt_r == push_wait;
    end
  end
endmodule // lvi_core_model

// ---- bench/test_lvi_level_irq.sv ----
// testbench: sources, levels, priority and vector fetch of the interrupt
`timescale 1ns/100ps

module test_lvi_level_irq;
  logic        sys_clk = 0, rst_n = 0, accept_en = 0;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb = 4'hF, push_wait = 0;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 1;
  logic        s_axi_arvalid = 0, s_axi_rready = 1, s_axi_awready;
  logic        s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [9:0]  ev = 0;
  logic        global_irq_on_instr = 0, global_irq_off_instr = 0;
  logic        cpu_irq_accept, cpu_push_done, irq_req_r, stack_push_r;
  logic        svc_valid_r;
  logic [15:0] svc_addr_r, reset_pc_r;
  logic [2:0]  grant_level_r;
  logic [7:0]  vb [256];
  int          error_cnt = 0, tests_run = 0, cyc = 0;
  // contention cases: priority, mask, sources, expected winner
  logic [7:0]  tp [7] = '{8'h00, 8'h00, 8'h00, 8'h02, 8'h01, 8'h80, 8'h00};
  logic [7:0]  tk [7] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFE};
  logic [9:0]  tm [7] = '{10'h003, 10'h018, 10'h009, 10'h009, 10'h005,
                          10'h081, 10'h009};
  int          tw [7] = '{0, 3, 0, 3, 2, 7, 3};

  lvi_level_irq DUT (.sys_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .tm0_ovf_evt(ev[0]), .tm0_cap_evt(ev[1]),
    .interval_evt(ev[2]), .cnt_ovf_evt(ev[3]), .cnt_cap_evt(ev[4]),
    .mm_bus_evt(ev[5]), .ext_pin_irq_a(ev[6]), .ext_pin_irq_b(ev[7]),
    .ext_pin_irq_c(ev[8]), .slave_bus_evt(ev[9]), .global_irq_on_instr,
    .global_irq_off_instr, .cpu_irq_accept, .cpu_push_done, .irq_req_r,
    .stack_push_r, .svc_valid_r, .svc_addr_r, .grant_level_r, .reset_pc_r);
  lvi_core_model u_core (.sys_clk, .rst_n, .accept_en, .push_wait,
    .stack_push_r, .cpu_irq_accept, .cpu_push_done);

  always #10 sys_clk = ~sys_clk;

  // hang guard, far above the length of the sequence below
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      error_cnt++;
      wrap_up();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // bready and rready stay high, so only the valids move
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (s_axi_bvalid !== 1'b1);
    rs = s_axi_bresp;
  endtask

  task automatic rdr(input logic [11:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
  endtask

  // one-cycle pulse on the chosen sources, then room for pin sync
  task automatic fire(input logic [9:0] m);
    ev <= m;
    @(posedge sys_clk);
    ev <= 0;
    repeat (3) @(posedge sys_clk);
    global_irq_on_instr <= 1;
    @(posedge sys_clk);
    global_irq_on_instr <= 0;
  endtask

  function automatic logic [2:0] lvl(input int i);
    return 3'((i < 2) ? 0 : (i < 5) ? (i + 1) / 2 : i - 2);
  endfunction

  // wait for the service strobe and compare target and level
  task automatic serv(input int i);
    int n;
    logic [7:0] v;
    n = 0;
    v = 8'hE0 + 8'(2 * i);
    while (svc_valid_r !== 1'b1 && n < 200) begin
      @(negedge sys_clk);
      n++;
    end
    check(n < 200, 1);
    check(svc_addr_r, {vb[v], vb[v + 8'h01]});
    check(grant_level_r, lvl(i));
    repeat (2) @(posedge sys_clk);
  endtask

  initial begin
    void'($urandom(32'hFD188788));
    repeat (8) @(posedge sys_clk);
    rst_n <= 1;
    @(posedge sys_clk);
    check(svc_addr_r, 16'h0100);
    rdr(lvi_pkg::OFS_MODE);
    check(rd, 0);
    for (int i = 8'hE0; i < 8'hF4; i++) begin
      vb[i] = 8'($urandom);
      wr(lvi_pkg::OFS_ROM_BASE + 12'(4 * i), {24'h0, vb[i]});
    end
    wr(12'h020, 0);
    check(rs, lvi_pkg::RESP_SLVERR);
    rdr(12'h020);
    check(rs, lvi_pkg::RESP_SLVERR);
    wr(lvi_pkg::OFS_MASK, 32'hFF);
    accept_en <= 1;
    for (int i = 0; i < 10; i++) begin
      push_wait <= 4'($urandom_range(6));
      fire(10'h1 << i);
      serv(i);
      rdr(lvi_pkg::OFS_PEND);
      check(rd[i], i > 3);
      wr(lvi_pkg::OFS_PEND, 32'h1 << i);
    end
    // core busy: request must show, then the off instruction withdraws it
    accept_en <= 0;
    fire(10'h004);
    repeat (2) @(posedge sys_clk);
    check(irq_req_r, 1);
    global_irq_off_instr <= 1;
    @(posedge sys_clk);
    global_irq_off_instr <= 0;
    repeat (3) @(posedge sys_clk);
    check(irq_req_r, 0);
    accept_en <= 1;
    fire(0);
    serv(2);
    for (int k = 0; k < 7; k++) begin
      wr(lvi_pkg::OFS_PRIO, {24'h0, tp[k]});
      wr(lvi_pkg::OFS_MASK, {24'h0, tk[k]});
      fire(tm[k]);
      serv(tw[k]);
      check(irq_req_r, 0);
      wr(lvi_pkg::OFS_PEND, 32'h3FF);
    end
    wrap_up();
  end
endmodule // test_lvi_level_irq
